// *** hw/paging_select.sv ***
`timescale 1ns/10ps

// Function
// - Program window drives program page onto lines
// - Call and return load program page automatically
// - Extra window drives extra page onto lines
// - Extra window forces lines 21-18 high
// - Data enable bit turns data paging on
// - Program enable bit turns program paging on
// - Extra enable bit turns extra paging on
// - Assign bit gives pin to expansion line
// - Single-chip mode ignores pin assign bits
// - Selects active low, pull-ups on inputs
// - Single-chip mode leaves select pins untouched
// - Follow selects decode above register block; select 3 may also decode in extra window
// - Follow selects cover their fixed offset ranges
// - Selects 3,2 beat 1; 3,2,1 beat 0
// - Program select A covers upper half
// - Program select B full or upper half
// - Split mode picks program select by line 21
// - Data select covers half map or window
// - Select 3 may follow the extra window
// - Each select stretches access 0-3 cycles
// - Data window drives data page, forces 21-20
// - One select at most, fixed priority order
module paging_select
  import paging_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic single_chip_i,
  input wire logic acc_i,
  input wire logic [15:0] cpu_addr_i,
  output logic [15:0] ext_addr_o,
  output logic access_end_o,
  input wire logic call_i,
  input wire logic [7:0] call_page_i,
  input wire logic rtc_i,
  input wire logic [7:0] rtc_page_i,
  output logic [7:0] program_page_o,
  input wire logic port_pullup_on_i,
  input wire logic [6:0] portf_dir_i,
  input wire logic [6:0] portf_data_i,
  input wire logic [6:0] portf_pin_i,
  output logic [6:0] portf_pin_o,
  output logic [6:0] portf_pin_oe_o,
  output logic [6:0] portf_pullup_o,
  input wire logic [5:0] expansion_port_direction_i,
  input wire logic [5:0] portg_data_i,
  input wire logic [5:0] portg_pin_i,
  output logic [5:0] portg_pin_o,
  output logic [5:0] portg_pin_oe_o,
  output logic [5:0] portg_pullup_o
);

  logic [7:0] map_cfg_ff, nxt_map_cfg;
  logic [7:0] data_window_page_ff, nxt_data_window_page;
  logic [7:0] program_window_page_ff, nxt_program_window_page;
  logic [7:0] extra_window_page_ff, nxt_extra_window_page;
  logic [7:0] window_enables_ff, nxt_window_enables;
  logic [7:0] expansion_pin_assign_ff, nxt_expansion_pin_assign;
  logic [7:0] select_enable_ctrl_ff, nxt_select_enable_ctrl;
  logic [7:0] select_range_ctrl_ff, nxt_select_range_ctrl;
  logic [7:0] select_stretch_lo_ff, nxt_select_stretch_lo;
  logic [7:0] select_stretch_hi_ff, nxt_select_stretch_hi;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  acc_state_t state_ff, nxt_state;
  ext_bus_t bus_ff, nxt_bus;
  logic [1:0] cnt_ff, nxt_cnt;
  logic end_ff, nxt_end;
  logic [6:0] pf_out_ff, nxt_pf_out, pf_oe_ff, nxt_pf_oe, pf_pu_ff, nxt_pf_pu;
  logic [5:0] pg_out_ff, nxt_pg_out, pg_oe_ff, nxt_pg_oe, pg_pu_ff, nxt_pg_pu;
  logic bus_req, bus_wr;
  logic [5:0] reg_idx;
  logic program_window_on, data_window_on, extra_window_on;
  logic in_block, in_regs, in_follow, in_ewin, in_pwin, in_dwin;
  logic [21:0] xaddr;
  logic [6:0] hit, grant, sel_en;
  logic [13:0] stretch_all;
  logic [1:0] stretch;
  logic [5:0] xline_on;

  assign reg_idx = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // Write lands at the edge where the master samples ack, not when the strobe is first seen
  assign bus_wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];
  assign program_window_on = window_enables_ff[WIN_PROG_ON];
  assign data_window_on = window_enables_ff[WIN_DATA_ON];
  assign extra_window_on = window_enables_ff[WIN_EXTRA_ON];
  assign sel_en = select_enable_ctrl_ff[6:0];
  assign stretch_all = {select_stretch_hi_ff[5:0], select_stretch_lo_ff};
  assign xline_on = expansion_pin_assign_ff[5:0];

  // Register writes; page loads from call/return win over a bus write
  always_comb begin
    nxt_map_cfg = map_cfg_ff;
    nxt_data_window_page = data_window_page_ff;
    nxt_program_window_page = program_window_page_ff;
    nxt_extra_window_page = extra_window_page_ff;
    nxt_window_enables = window_enables_ff;
    nxt_expansion_pin_assign = expansion_pin_assign_ff;
    nxt_select_enable_ctrl = select_enable_ctrl_ff;
    nxt_select_range_ctrl = select_range_ctrl_ff;
    nxt_select_stretch_lo = select_stretch_lo_ff;
    nxt_select_stretch_hi = select_stretch_hi_ff;
    if (bus_wr) begin
      case (reg_idx)
        IDX_MAP_CFG: nxt_map_cfg = wb_dat_i[7:0];
        IDX_DATA_PAGE: nxt_data_window_page = wb_dat_i[7:0];
        IDX_PROG_PAGE: nxt_program_window_page = wb_dat_i[7:0];
        IDX_EXTRA_PAGE: nxt_extra_window_page = wb_dat_i[7:0];
        IDX_WIN_EN: nxt_window_enables = wb_dat_i[7:0];
        IDX_PIN_ASSIGN: nxt_expansion_pin_assign = wb_dat_i[7:0];
        IDX_SEL_EN: nxt_select_enable_ctrl = wb_dat_i[7:0];
        IDX_SEL_RANGE: nxt_select_range_ctrl = wb_dat_i[7:0];
        IDX_STRETCH_LO: nxt_select_stretch_lo = wb_dat_i[7:0];
        IDX_STRETCH_HI: nxt_select_stretch_hi = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (call_i) begin
      nxt_program_window_page = call_page_i;
    end else if (rtc_i) begin
      nxt_program_window_page = rtc_page_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map_cfg_ff <= RESET_BYTE;
      data_window_page_ff <= RESET_BYTE;
      program_window_page_ff <= RESET_BYTE;
      extra_window_page_ff <= RESET_BYTE;
      window_enables_ff <= RESET_BYTE;
      expansion_pin_assign_ff <= RESET_BYTE;
      select_enable_ctrl_ff <= RESET_BYTE;
      select_range_ctrl_ff <= RESET_BYTE;
      select_stretch_lo_ff <= RESET_BYTE;
      select_stretch_hi_ff <= RESET_BYTE;
    end else begin
      map_cfg_ff <= nxt_map_cfg;
      data_window_page_ff <= nxt_data_window_page;
      program_window_page_ff <= nxt_program_window_page;
      extra_window_page_ff <= nxt_extra_window_page;
      window_enables_ff <= nxt_window_enables;
      expansion_pin_assign_ff <= nxt_expansion_pin_assign;
      select_enable_ctrl_ff <= nxt_select_enable_ctrl;
      select_range_ctrl_ff <= nxt_select_range_ctrl;
      select_stretch_lo_ff <= nxt_select_stretch_lo;
      select_stretch_hi_ff <= nxt_select_stretch_hi;
    end
  end

  // Wishbone answer one cycle after the strobe; unmapped reads give zero
  always_comb begin
    nxt_ack = bus_req;
    nxt_rdata = rdata_ff;
    if (bus_req) begin
      nxt_rdata = '0;
      case (reg_idx)
        IDX_MAP_CFG: nxt_rdata[7:0] = map_cfg_ff;
        IDX_DATA_PAGE: nxt_rdata[7:0] = data_window_page_ff;
        IDX_PROG_PAGE: nxt_rdata[7:0] = program_window_page_ff;
        IDX_EXTRA_PAGE: nxt_rdata[7:0] = extra_window_page_ff;
        IDX_WIN_EN: nxt_rdata[7:0] = window_enables_ff;
        IDX_PIN_ASSIGN: nxt_rdata[7:0] = expansion_pin_assign_ff;
        IDX_STATUS: nxt_rdata[7:0] = {state_ff == ACC_HOLD, ~bus_ff.sel_n};
        IDX_PINS_F: nxt_rdata[6:0] = portf_pin_i;
        IDX_PINS_G: nxt_rdata[5:0] = portg_pin_i;
        IDX_SEL_EN: nxt_rdata[7:0] = select_enable_ctrl_ff;
        IDX_SEL_RANGE: nxt_rdata[7:0] = select_range_ctrl_ff;
        IDX_STRETCH_LO: nxt_rdata[7:0] = select_stretch_lo_ff;
        IDX_STRETCH_HI: nxt_rdata[7:0] = select_stretch_hi_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Window decode; the internal register block blocks every external space
  always_comb begin
    // follow selects sit in block above the registers
    in_block = cpu_addr_i[15:11] == map_cfg_ff[4:0];
    in_regs = in_block & (cpu_addr_i[10:9] == OFF_REGS);
    in_follow = in_block & (cpu_addr_i[10:9] == OFF_FOLLOW);
    in_ewin = cpu_addr_i[15:10] == (map_cfg_ff[CFG_EXTRA_LOW] ? EXTRA_AT_0000 : EXTRA_AT_0400);
    in_pwin = cpu_addr_i[15:14] == PROG_WIN_TOP;
    in_dwin = cpu_addr_i[15:12] == DATA_WIN_TOP;
    xaddr = {UNPAGED_HIGH, cpu_addr_i};
    if (!in_regs) begin
      if (extra_window_on && in_ewin) begin
        xaddr = {EXTRA_FORCE, extra_window_page_ff, cpu_addr_i[9:0]};
      end else if (program_window_on && in_pwin) begin
        xaddr = {program_window_page_ff, cpu_addr_i[13:0]};
      end else if (data_window_on && in_dwin) begin
        xaddr = {DATA_FORCE, data_window_page_ff, cpu_addr_i[11:0]};
      end
    end
  end

  // Raw select hits before priority
  always_comb begin
    hit[SEL_RF0] = in_follow;
    hit[SEL_RF1] = in_follow & cpu_addr_i[8];
    hit[SEL_RF2] = in_follow & cpu_addr_i[8] & cpu_addr_i[7];
    // select 3 may follow the extra window
    hit[SEL_RF3] = (in_follow & ~cpu_addr_i[8] & cpu_addr_i[7])
                 | (select_range_ctrl_ff[RNG_SEL3_EXTRA] & extra_window_on & in_ewin);
    hit[SEL_PROG_A] = cpu_addr_i[15] & (~select_range_ctrl_ff[RNG_SPLIT_TOP] | xaddr[21]);
    // data select half map or window only
    hit[SEL_DATA] = select_range_ctrl_ff[RNG_DATA_HALF] ? ~cpu_addr_i[15] : in_dwin;
    // program select B full map or upper half
    if (select_range_ctrl_ff[RNG_SPLIT_TOP]) begin
      hit[SEL_PROG_B] = cpu_addr_i[15] & ~xaddr[21];
    end else begin
      hit[SEL_PROG_B] = select_range_ctrl_ff[RNG_PROG_B_FULL] | cpu_addr_i[15];
    end
    hit = hit & sel_en & {NUM_SEL{~in_regs}};
  end

  // Priority resolve and stretch lookup of the winner
  always_comb begin
    grant = '0;
    if (hit[SEL_RF3]) begin
      grant[SEL_RF3] = 1'b1;
    end else if (hit[SEL_RF2]) begin
      grant[SEL_RF2] = 1'b1;
    end else if (hit[SEL_RF1]) begin
      grant[SEL_RF1] = 1'b1;
    end else if (hit[SEL_RF0]) begin
      grant[SEL_RF0] = 1'b1;
    end else if (hit[SEL_PROG_A]) begin
      grant[SEL_PROG_A] = 1'b1;
    end else if (hit[SEL_DATA]) begin
      grant[SEL_DATA] = 1'b1;
    end else if (hit[SEL_PROG_B]) begin
      grant[SEL_PROG_B] = 1'b1;
    end
    // two-bit field per select, A bit high
    stretch = NO_STRETCH;
    for (int i = 0; i < NUM_SEL; i++) begin
      if (grant[i]) begin
        stretch = stretch_all[2*i +: 2];
      end
    end
  end

  // Access sequencer: latch translated lines and hold them through stretch
  always_comb begin
    nxt_state = state_ff;
    nxt_bus = bus_ff;
    nxt_cnt = cnt_ff;
    nxt_end = 1'b0;
    case (state_ff)
      ACC_IDLE: begin
        if (acc_i) begin
          nxt_bus = '{addr: xaddr, sel_n: ~grant};
          nxt_cnt = stretch;
          nxt_state = ACC_HOLD;
        end
      end
      ACC_HOLD: begin
        // lines frozen until the count runs out
        if (cnt_ff == NO_STRETCH) begin
          nxt_state = ACC_IDLE;
          nxt_bus.sel_n = BUS_IDLE.sel_n;
          nxt_end = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 2'd1;
        end
      end
      default: nxt_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ACC_IDLE;
      bus_ff <= BUS_IDLE;
      cnt_ff <= NO_STRETCH;
      end_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bus_ff <= nxt_bus;
      cnt_ff <= nxt_cnt;
      end_ff <= nxt_end;
    end
  end

  // Pin muxing from next bus values so pins line up with the bus outputs
  always_comb begin
    if (single_chip_i) begin
      nxt_pg_oe = expansion_port_direction_i;
      nxt_pg_out = portg_data_i;
      nxt_pf_oe = portf_dir_i;
      nxt_pf_out = portf_data_i;
    end else begin
      nxt_pg_oe = xline_on | expansion_port_direction_i;
      nxt_pg_out = (xline_on & nxt_bus.addr[21:16]) | (~xline_on & portg_data_i);
      nxt_pf_oe = sel_en | portf_dir_i;
      nxt_pf_out = (sel_en & nxt_bus.sel_n) | (~sel_en & portf_data_i);
    end
    // pull-ups only on inputs when enabled
    nxt_pf_pu = {NUM_SEL{port_pullup_on_i}} & ~nxt_pf_oe;
    nxt_pg_pu = {NUM_XLINE{port_pullup_on_i}} & ~nxt_pg_oe;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pf_out_ff <= '0;
      pf_oe_ff <= '0;
      pf_pu_ff <= '0;
      pg_out_ff <= '0;
      pg_oe_ff <= '0;
      pg_pu_ff <= '0;
    end else begin
      pf_out_ff <= nxt_pf_out;
      pf_oe_ff <= nxt_pf_oe;
      pf_pu_ff <= nxt_pf_pu;
      pg_out_ff <= nxt_pg_out;
      pg_oe_ff <= nxt_pg_oe;
      pg_pu_ff <= nxt_pg_pu;
    end
  end

  // Outputs, all from flip-flops
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign ext_addr_o = bus_ff.addr[15:0];
  assign access_end_o = end_ff;
  assign program_page_o = program_window_page_ff;
  assign portf_pin_o = pf_out_ff;
  assign portf_pin_oe_o = pf_oe_ff;
  assign portf_pullup_o = pf_pu_ff;
  assign portg_pin_o = pg_out_ff;
  assign portg_pin_oe_o = pg_oe_ff;
  assign portg_pullup_o = pg_pu_ff;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [2:0] hold_len_ff;
  logic [1:0] hold_want_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == ACC_IDLE) begin
      hold_len_ff <= '0;
      hold_want_ff <= acc_i ? stretch : NO_STRETCH;
    end else begin
      hold_len_ff <= hold_len_ff + 3'd1;
    end
  end

  a_one_select: assert property ($countones(~bus_ff.sel_n) <= 1)
    else $error("more than one select active");
  a_prog_xlate: assert property ((state_ff == ACC_IDLE) && acc_i && program_window_on && in_pwin
      && !in_ewin && !in_regs |=> bus_ff.addr[21:14] == $past(program_window_page_ff))
    else $error("program page not on upper lines");
  a_extra_high: assert property ((state_ff == ACC_IDLE) && acc_i && extra_window_on && in_ewin
      && !in_regs |=> bus_ff.addr[21:18] == EXTRA_FORCE && bus_ff.addr[17:10] == $past(extra_window_page_ff))
    else $error("extra window lines wrong");
  a_data_xlate: assert property ((state_ff == ACC_IDLE) && acc_i && data_window_on && in_dwin
      && !in_ewin && !in_regs |=> bus_ff.addr[21:12] == {DATA_FORCE, $past(data_window_page_ff)})
    else $error("data page not on lines");
  a_stretch_len: assert property ((state_ff == ACC_HOLD) && (nxt_state == ACC_IDLE)
      |-> hold_len_ff == {1'b0, hold_want_ff})
    else $error("stretch length wrong");
  a_hold_stable: assert property ((state_ff == ACC_HOLD) ##1 (state_ff == ACC_HOLD)
      |-> $stable(bus_ff) && $stable(pg_out_ff))
    else $error("lines moved during stretch");
  a_regs_quiet: assert property ((state_ff == ACC_IDLE) && acc_i && in_regs
      |=> bus_ff.sel_n == BUS_IDLE.sel_n)
    else $error("select in register space");
  a_single_chip: assert property (single_chip_i
      |=> portf_pin_oe_o == $past(portf_dir_i) && portg_pin_oe_o == $past(expansion_port_direction_i))
    else $error("pins taken in single-chip mode");
  a_pin_assign: assert property (!single_chip_i |=> (portg_pin_oe_o & $past(xline_on)) == $past(xline_on))
    else $error("assigned line not driven");
  a_call_page: assert property (call_i |=> program_page_o == $past(call_page_i))
    else $error("call did not load page");
  a_pullup_in: assert property ((portf_pullup_o & portf_pin_oe_o) == '0)
    else $error("pull-up on driven pin");

  c_stretched: cover property ((state_ff == ACC_IDLE) && acc_i && stretch == 2'd3);
  c_prog_page: cover property ((state_ff == ACC_IDLE) && acc_i && program_window_on && in_pwin);
  c_sel3_extra: cover property ((state_ff == ACC_IDLE) && acc_i && grant[SEL_RF3] && in_ewin);

endmodule : paging_select

// *** hw/paging_select_pkg.sv ***
package paging_select_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_MAP_CFG = 6'h30;
  localparam logic [5:0] IDX_DATA_PAGE = 6'h34;
  localparam logic [5:0] IDX_PROG_PAGE = 6'h35;
  localparam logic [5:0] IDX_EXTRA_PAGE = 6'h36;
  localparam logic [5:0] IDX_WIN_EN = 6'h37;
  localparam logic [5:0] IDX_PIN_ASSIGN = 6'h38;
  localparam logic [5:0] IDX_STATUS = 6'h39;
  localparam logic [5:0] IDX_PINS_F = 6'h3a;
  localparam logic [5:0] IDX_PINS_G = 6'h3b;
  localparam logic [5:0] IDX_SEL_EN = 6'h3c;
  localparam logic [5:0] IDX_SEL_RANGE = 6'h3d;
  localparam logic [5:0] IDX_STRETCH_LO = 6'h3e;
  localparam logic [5:0] IDX_STRETCH_HI = 6'h3f;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Field positions
  localparam int WIN_DATA_ON = 7;
  localparam int WIN_PROG_ON = 6;
  localparam int WIN_EXTRA_ON = 5;
  localparam int RNG_SPLIT_TOP = 6;
  localparam int RNG_PROG_B_FULL = 5;
  localparam int RNG_DATA_HALF = 4;
  localparam int RNG_SEL3_EXTRA = 3;
  localparam int CFG_EXTRA_LOW = 7;

  // Select indices, also the bit of the enable register and port F pin
  localparam int SEL_RF0 = 0;
  localparam int SEL_RF1 = 1;
  localparam int SEL_RF2 = 2;
  localparam int SEL_RF3 = 3;
  localparam int SEL_PROG_A = 4;
  localparam int SEL_DATA = 5;
  localparam int SEL_PROG_B = 6;
  localparam int NUM_SEL = 7;
  localparam int NUM_XLINE = 6;

  // Address window decode constants
  localparam logic [1:0] PROG_WIN_TOP = 2'b10;
  localparam logic [3:0] DATA_WIN_TOP = 4'h7;
  localparam logic [5:0] EXTRA_AT_0000 = 6'h00;
  localparam logic [5:0] EXTRA_AT_0400 = 6'h01;
  localparam logic [1:0] OFF_REGS = 2'b00;
  localparam logic [1:0] OFF_FOLLOW = 2'b01;
  localparam logic [5:0] UNPAGED_HIGH = 6'h3f;
  localparam logic [3:0] EXTRA_FORCE = 4'hf;
  localparam logic [1:0] DATA_FORCE = 2'b11;
  localparam logic [1:0] NO_STRETCH = 2'b00;

  typedef enum logic {ACC_IDLE, ACC_HOLD} acc_state_t;

  // Translated address and select lines, moved as one unit
  typedef struct packed {
    logic [21:0] addr;
    logic [6:0] sel_n;
  } ext_bus_t;

  localparam ext_bus_t BUS_IDLE = '{addr: 22'h3fffff, sel_n: 7'h7f};

endpackage : paging_select_pkg

// *** sim/ext_dev_model.sv ***
`timescale 1ns/10ps
// Board side of ports F and G: devices read the pins and only drive them when the block floats them
module ext_dev_model (
  input wire logic clk_i,
  input wire logic [12:0] pin_i,
  input wire logic [12:0] oe_i,
  input wire logic [12:0] pu_i,
  output logic [12:0] level_o
);
  logic [12:0] drift_ff = 13'h0aaa;
  // A floating line without pull-up keeps changing, so a stale value never passes for a driven one
  always_ff @(posedge clk_i) begin
    drift_ff <= ~drift_ff;
  end
  assign level_o = (oe_i & pin_i) | (~oe_i & (pu_i | drift_ff));
endmodule : ext_dev_model

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import paging_select_pkg::*;
;
  logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, sc, acc, call, rtc, pu, ack, aend;
  logic [7:0] adr, cpage, rpage, ppo;
  logic [31:0] wdat, rdat, q;
  logic [3:0] wsel;
  logic [15:0] caddr, xaddr, ra;
  logic [6:0] fdir, fdat, fo, foe, fpu;
  logic [5:0] gdir, gdat, go, goe, gpu;
  wire [6:0] fi;
  wire [5:0] gi;
  logic [7:0] sh [0:63];
  logic [15:0] at [12] = '{16'h0412, 16'h7123, 16'h8456, 16'hc001, 16'h0a00, 16'h0a80,
                           16'h0b00, 16'h0b80, 16'h0900, 16'h2000, 16'h8000, 16'hc000};
  int wl [10] = '{48, 52, 53, 54, 55, 56, 60, 61, 62, 63};
  int bad_count, num_checks, seed;

  paging_select paging_select_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(wsel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .single_chip_i(sc), .acc_i(acc), .cpu_addr_i(caddr), .ext_addr_o(xaddr), .access_end_o(aend),
    .call_i(call), .call_page_i(cpage), .rtc_i(rtc), .rtc_page_i(rpage), .program_page_o(ppo),
    .port_pullup_on_i(pu), .portf_dir_i(fdir), .portf_data_i(fdat), .portf_pin_i(fi), .portf_pin_o(fo),
    .portf_pin_oe_o(foe), .portf_pullup_o(fpu), .expansion_port_direction_i(gdir), .portg_data_i(gdat),
    .portg_pin_i(gi), .portg_pin_o(go), .portg_pin_oe_o(goe), .portg_pullup_o(gpu));
  ext_dev_model ext_dev_model_inst (.clk_i(clk_i), .pin_i({go, fo}), .oe_i({goe, foe}), .pu_i({gpu, fpu}),
    .level_o({gi, fi}));

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Classic single Wishbone cycle; shadow copy follows what a write may change
  task automatic wb(input logic [5:0] idx, input logic we, input logic [3:0] s, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    wdat <= {~d, 8'h5a, d ^ 8'h3c, d};
    wsel <= s;
    wb_we <= we;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    if (n == 20) begin
      bad_count++;
      conclude();
    end
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (we && s[0] && (idx inside {IDX_MAP_CFG, [IDX_DATA_PAGE:IDX_PIN_ASSIGN], [IDX_SEL_EN:IDX_STRETCH_HI]}))
      sh[idx] = d;
  endtask : wb

  task automatic reg_chk(input logic [5:0] idx);
    wb(idx, 1'b0, 4'hf, 8'h00);
    chk(q, {24'h0, sh[idx]});
  endtask : reg_chk

  // Expected {stretch, F pins, F enables, G pins, G enables, address} for one access
  function automatic logic [43:0] expect_bus(input logic [15:0] a);
    logic [7:0] cf, wn, se, sr;
    logic [5:0] ln, pa, gp, ge;
    logic [15:0] ad;
    logic [6:0] hit, sn, fp, fe;
    logic [1:0] s;
    logic blk, fol, xw;
    int ord [7];
    ord = '{6, 5, 4, 0, 1, 2, 3};
    cf = sh[IDX_MAP_CFG];
    wn = sh[IDX_WIN_EN];
    se = sh[IDX_SEL_EN];
    sr = sh[IDX_SEL_RANGE];
    blk = a[15:11] == cf[4:0] && a[10:9] == OFF_REGS;
    fol = a[15:11] == cf[4:0] && a[10:9] == OFF_FOLLOW;
    xw = wn[WIN_EXTRA_ON] && a[15:10] == (cf[CFG_EXTRA_LOW] ? EXTRA_AT_0000 : EXTRA_AT_0400);
    ad = a;
    ln = UNPAGED_HIGH;
    if (!blk && xw) {ln, ad} = {EXTRA_FORCE, sh[IDX_EXTRA_PAGE], a[9:0]};
    else if (!blk && wn[WIN_PROG_ON] && a[15:14] == PROG_WIN_TOP) {ln, ad} = {sh[IDX_PROG_PAGE], a[13:0]};
    else if (!blk && wn[WIN_DATA_ON] && a[15:12] == DATA_WIN_TOP) {ln, ad} = {DATA_FORCE, sh[IDX_DATA_PAGE], a[11:0]};
    hit[3] = (fol && a[8:7] == 2'b01) || (sr[RNG_SEL3_EXTRA] && xw);
    hit[2] = fol && a[8:7] == 2'b11;
    hit[1] = fol && a[8];
    hit[0] = fol;
    hit[4] = a[15] && (!sr[RNG_SPLIT_TOP] || ln[5]);
    hit[5] = sr[RNG_DATA_HALF] ? !a[15] : a[15:12] == DATA_WIN_TOP;
    hit[6] = sr[RNG_SPLIT_TOP] ? a[15] && !ln[5] : sr[RNG_PROG_B_FULL] || a[15];
    hit = blk ? 7'h00 : hit & se[6:0];
    sn = 7'h7f;
    s = NO_STRETCH;
    foreach (ord[i]) if (hit[ord[i]]) begin
      sn = ~(7'h01 << ord[i]);
      s = ord[i] < 4 ? sh[IDX_STRETCH_LO][2*ord[i] +: 2] : sh[IDX_STRETCH_HI][2*(ord[i]-4) +: 2];
    end
    fe = sc ? fdir : se[6:0] | fdir;
    fp = sc ? fdat : (se[6:0] & sn) | (~se[6:0] & fdat);
    pa = sh[IDX_PIN_ASSIGN][5:0] & {6{!sc}};
    ge = pa | gdir;
    gp = (pa & ln) | (~pa & gdat);
    return {s, fp, fe, gp, ge, ad};
  endfunction : expect_bus

  // One bus access: lines are compared every cycle until the end pulse
  task automatic access(input logic [15:0] a);
    logic [43:0] e;
    int n;
    @(posedge clk_i);
    // Expectation taken after the edge so pin and mode changes made at it are settled
    e = expect_bus(a);
    acc <= 1'b1;
    caddr <= a;
    @(posedge clk_i);
    acc <= 1'b0;
    for (n = 1; n < 9; n++) begin
      #1;
      if (aend === 1'b1) break;
      chk({fo, foe, go, goe, xaddr & {16{!sc}}}, e[41:0] & {26'h3ffffff, {16{!sc}}});
      chk({fpu, gpu}, {{7{pu}} & ~e[34:28], {6{pu}} & ~e[21:16]});
      @(posedge clk_i);
    end
    if (!sc) chk(64'(n), 64'(e[43:42]) + 64'd2);
  endtask : access

  initial begin
    {wb_we, wb_cyc, wb_stb, sc, acc, call, rtc, pu, adr, cpage, rpage, wdat, wsel, caddr} = '0;
    {fdir, fdat, gdir, gdat} = {7'h0f, 7'h55, 6'h0c, 6'h2a};
    foreach (sh[i]) sh[i] = RESET_BYTE;
    seed = 32'ha68d;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 64; i++) if (!(i inside {[58:59]})) reg_chk(6'(i));
    $display("test reset_values done");
    foreach (wl[i]) begin
      wb(6'(wl[i]), 1'b1, 4'($random(seed)), 8'($random(seed)));
      reg_chk(6'(wl[i]));
    end
    wb(6'h10, 1'b1, 4'hf, 8'hff);
    reg_chk(6'h10);
    $display("test register_access done");
    @(posedge clk_i);
    {call, cpage, rtc, rpage} <= {1'b1, 8'h5c, 1'b1, 8'h13};
    @(posedge clk_i);
    call <= 1'b0;
    #1 chk(ppo, 8'h5c);
    @(posedge clk_i);
    rtc <= 1'b0;
    #1 chk(ppo, 8'h13);
    sh[IDX_PROG_PAGE] = 8'h13;
    reg_chk(IDX_PROG_PAGE);
    $display("test call_return done");
    // program select and select 3 follow-extra with paging
    foreach (wl[i]) wb(6'(wl[i]), 1'b1, 4'hf, 8'({32'h01, 32'hf3, 32'ha6, 32'h9d, 32'he0, 32'h01, 32'h38, 32'h18,
      32'hb1, 32'h27} >> (32 * (9 - i))));
    for (int i = 0; i < 4; i++) access(at[i]);
    wb(IDX_SEL_EN, 1'b1, 4'hf, 8'h7f);
    wb(IDX_SEL_RANGE, 1'b1, 4'hf, 8'h00);
    wb(IDX_STRETCH_LO, 1'b1, 4'hf, 8'he4);
    wb(IDX_STRETCH_HI, 1'b1, 4'hf, 8'h39);
    foreach (at[i]) access(at[i]);
    wb(IDX_SEL_RANGE, 1'b1, 4'hf, 8'h70);
    foreach (at[i]) access(at[i]);
    $display("test directed_map done");
    for (int t = 0; t < 200; t++) begin
      foreach (wl[i]) wb(6'(wl[i]), 1'b1, 4'hf, 8'($random(seed)));
      @(posedge clk_i);
      sc <= ($random(seed) & 32'h7) == 32'h0;
      {pu, fdir, fdat, gdir, gdat} <= 27'($random(seed));
      for (int k = 0; k < 4; k++) begin
        ra = 16'($random(seed));
        case (ra[1:0])
          2'd0: ra[15:9] = {sh[IDX_MAP_CFG][4:0], OFF_FOLLOW};
          2'd1: ra[15:10] = {5'h00, !sh[IDX_MAP_CFG][CFG_EXTRA_LOW]};
          2'd2: ra[15:12] = DATA_WIN_TOP;
          default: ;
        endcase
        access(ra);
      end
    end
    $display("test random_map done");
    conclude();
  end
endmodule : tb_top
